// ### hw/tmc_defs.svh
// Offsets, field positions, reset values and constants of the mode configuration block.
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
// Register index of the mode settings; its byte address is four times the index.
`define TMC_IDX_MODE         8'h11
`define TMC_ADDR_MODE        8'h44
`define TMC_ADDR_EVT_STATUS  8'h80
`define TMC_ADDR_EVT_MASK    8'h84
`define TMC_RESET_MODE       8'h3b
`define TMC_BIT_ORDER        7
`define TMC_BIT_SYNC         6
`define TMC_BIT_TX_WAIT      5
`define TMC_BIT_RX_WAIT      4
`define TMC_BIT_POLARITY     3
`define TMC_BIT_MDET_OFF     2
`define TMC_SYNC_BYTE        8'hf0
`define TMC_PRESET_0         16'h0000
`define TMC_PRESET_1         16'h6363
`define TMC_PRESET_2         16'ha671
`define TMC_PRESET_3         16'hffff
`define TMC_RESP_OKAY        2'b00
`define TMC_RESP_SLVERR      2'b10
`endif

// ### hw/tmc_pkg.sv
// Types shared by the mode configuration block.
package tmc_pkg;
	typedef enum logic [1:0] {
		TMC_CRC_ZERO = 2'h0,
		TMC_CRC_6363 = 2'h1,
		TMC_CRC_A671 = 2'h2,
		TMC_CRC_FFFF = 2'h3
	} tmc_preset_t;
	typedef enum logic [2:0] {
		TMC_SYNC_OFF  = 3'b001,
		TMC_SYNC_HUNT = 3'b010,
		TMC_SYNC_OPEN = 3'b100
	} tmc_sync_t;
endpackage : tmc_pkg

// ### hw/tmc_crc_select.sv
// Picks the CRC start value and bit order used by the CRC co-processor.
`timescale 1ns/100ps
`include "tmc_defs.svh"
module tmc_crc_select (
	// Configuration.
	input  wire logic [1:0]  preset_select,
	input  wire logic        bit_order_flag,
	// Context from the transceiver.
	input  wire logic        rf_active,
	input  wire logic        proto_msb_first,
	input  wire logic [15:0] proto_preset,
	// Result.
	output logic      [15:0] crc_preset,
	output logic             crc_msb_first
);
	// Standalone presets; communication uses protocol-defined values instead.
	wire [15:0] table_value = (tmc_pkg::tmc_preset_t'(preset_select) == tmc_pkg::TMC_CRC_ZERO) ?
		`TMC_PRESET_0 :
		(tmc_pkg::tmc_preset_t'(preset_select) == tmc_pkg::TMC_CRC_6363) ? `TMC_PRESET_1 :
		(tmc_pkg::tmc_preset_t'(preset_select) == tmc_pkg::TMC_CRC_A671) ? `TMC_PRESET_2 :
		`TMC_PRESET_3; // R12
	assign crc_preset    = rf_active ? proto_preset : table_value; // R13
	assign crc_msb_first = rf_active ? proto_msb_first : bit_order_flag; // R1 R2
endmodule : tmc_crc_select

// ### hw/tmc_mode_config.sv
// General mode settings register of the contactless transceiver with AXI4-Lite access.
//
// How it works
// R1 - With the bit-order flag set the CRC runs MSB first and both result bytes come out reversed.
// R2 - During RF communication the protocol sets the CRC bit order and the flag is ignored.
// R3 - With sync detect set the UART receiver waits for F0h and F0h is sent ahead of each frame; the code does this only while mode_106k_active is high.
// R4 - Software keeps sync detect at zero except for 106 kbit NFCIP-1 data exchange.
// R5 - With transmit-wait set the transmitter starts as reader or initiator only with own field on.
// R6 - With receive-wait set the receive-wait counter starts as target or card only in a field.
// R7 - The polarity flag makes the envelope pin active high when 1 and active low when 0.
// R8 - A write that changes the polarity flag raises the envelope activity event.
// R9 - The internal envelope signal is always active low.
// R10 - The mode-detector-off flag disables the internal mode detector.
// R11 - The mode detector runs only while the automatic anticollision command executes.
// R12 - The preset field picks 0000, 6363, A671 or FFFF for the standalone CRC command.
// R13 - During communication the preset comes from the transmit and receive mode settings.
// R14 - The register sits at 11h, resets to 3Bh and all bits are read and write.
// R15 - A read returns all eight last-written bits and has no side effect.
//
// Register map: mode settings is register 11h at byte address 44h, event status sits at 80h
// and event mask at 84h. Each register takes one aligned word; unused bits read as zero.
// Only byte lane 0 carries register bits, so a write without its strobe changes nothing.
// Unmapped addresses answer SLVERR and change nothing.
//
// Limitations: a start request that meets a closed field gate is dropped, not held, so the
// transceiver asks again once the field is there. The sync hunt restarts on every frame
// start seen while the receiver is open.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tmc_defs.svh"
module tmc_mode_config (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt.
	output logic             irq,
	// Transceiver context.
	input  wire logic        rf_active,
	input  wire logic        proto_msb_first,
	input  wire logic [15:0] proto_preset,
	input  wire logic        mode_106k_active,
	input  wire logic        reader_or_initiator,
	input  wire logic        target_or_card,
	input  wire logic        own_field_on,
	input  wire logic        external_field_seen,
	input  wire logic        tx_start_request,
	input  wire logic        rx_wait_start_request,
	input  wire logic        anticollision_running,
	// Contactless UART byte stream.
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_byte_valid,
	input  wire logic        frame_start,
	// External envelope pin.
	input  wire logic        envelope_input_pin,
	// Controls to the transceiver.
	output logic [15:0]      crc_preset,
	output logic             crc_msb_first,
	output logic             crc_result_reverse,
	output logic             rx_enable,
	output logic             send_sync_byte,
	output logic             tx_start,
	output logic             rx_wait_start,
	output logic             mode_detector_enable,
	output logic             envelope_internal_n,
	output logic [7:0]       mode_settings
);
	//------------------------------------------------------------------
	// Register state
	//------------------------------------------------------------------
	logic [7:0]  general_mode_settings;
	// One event source, envelope activity, kept in bit 0 of status and mask.
	logic        evt_status;
	logic        evt_mask;
	tmc_pkg::tmc_sync_t sync_state;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Aligned word compare used by both address paths.
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offs);
		addr_is = (addr[7:2] == offs[7:2]);
	endfunction : addr_is

	//------------------------------------------------------------------
	// Write path
	//------------------------------------------------------------------
	// Write commits once both address and data are held and no response waits.
	wire        do_write   = aw_held && w_held && !s_axi_bvalid;
	wire        wr_mode    = addr_is(aw_addr, `TMC_ADDR_MODE);
	wire        wr_status  = addr_is(aw_addr, `TMC_ADDR_EVT_STATUS);
	wire        wr_mask    = addr_is(aw_addr, `TMC_ADDR_EVT_MASK);
	wire        wr_hit     = wr_mode || wr_status || wr_mask;
	wire        mode_we    = do_write && wr_mode && w_strb[0];
	wire [7:0]  next_mode  = mode_we ? w_data[7:0] : general_mode_settings; // R14
	wire        pol_change = mode_we &&
		(w_data[`TMC_BIT_POLARITY] != general_mode_settings[`TMC_BIT_POLARITY]); // R8
	wire        clr_evt    = do_write && wr_status && w_strb[0] && w_data[0];
	// Mask writes take bit 0 only; the other bits of the word are ignored.
	wire        mask_we    = do_write && wr_mask && w_strb[0];
	wire        next_mask  = mask_we ? w_data[0] : evt_mask;
	// A new event wins over a clear that lands in the same cycle.
	wire        next_status = pol_change || (evt_status && !clr_evt); // R8

	// Address and data channels are taken independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Ready flags and write response.
	// A ready drops the cycle after its channel is taken, so each channel holds one item.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TMC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Mode register, event status and mask; a new event wins over a clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_mode_settings <= `TMC_RESET_MODE; // R14
			evt_status            <= 1'b0;
			evt_mask              <= 1'b0;
		end else begin
			general_mode_settings <= next_mode;
			evt_status            <= next_status; // R8
			evt_mask              <= next_mask;
		end
	end

	//------------------------------------------------------------------
	// Read path
	//------------------------------------------------------------------
	// Reads have no side effect on any state.
	wire        rd_mode   = addr_is(s_axi_araddr, `TMC_ADDR_MODE);
	wire        rd_status = addr_is(s_axi_araddr, `TMC_ADDR_EVT_STATUS);
	wire        rd_mask   = addr_is(s_axi_araddr, `TMC_ADDR_EVT_MASK);
	wire        rd_hit    = rd_mode || rd_status || rd_mask;
	// Status and mask hold one bit each, in bit 0.
	wire [31:0] rd_value  = rd_mode   ? {24'h000000, general_mode_settings} : // R15
		rd_status ? {31'h0, evt_status} :
		rd_mask   ? {31'h0, evt_mask} : 32'h0000_0000;

	// One read at a time; answer one cycle after the address is taken.
	// A refused read still answers, with SLVERR and zero data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `TMC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_value;
				s_axi_rresp  <= rd_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------------
	// Contactless UART sync handling
	//------------------------------------------------------------------
	wire sync_on = general_mode_settings[`TMC_BIT_SYNC] && mode_106k_active; // R4
	tmc_pkg::tmc_sync_t next_sync;

	// Receiver is held off after each frame start until F0h arrives.
	// Dropping sync or leaving the 106 kbit mode returns at once to the idle state,
	// so a stale hunt never blocks the receiver in another mode.
	always_comb begin
		next_sync = sync_state;
		case (sync_state)
			tmc_pkg::TMC_SYNC_OFF: begin
				if (sync_on) begin
					next_sync = tmc_pkg::TMC_SYNC_HUNT;
				end
			end
			tmc_pkg::TMC_SYNC_HUNT: begin
				if (!sync_on) begin
					next_sync = tmc_pkg::TMC_SYNC_OFF;
				end else if (rx_byte_valid && rx_byte == `TMC_SYNC_BYTE) begin
					next_sync = tmc_pkg::TMC_SYNC_OPEN; // R3
				end
			end
			tmc_pkg::TMC_SYNC_OPEN: begin
				if (!sync_on) begin
					next_sync = tmc_pkg::TMC_SYNC_OFF;
				end else if (frame_start) begin
					next_sync = tmc_pkg::TMC_SYNC_HUNT;
				end
			end
			default: begin
				next_sync = tmc_pkg::TMC_SYNC_OFF;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_state <= tmc_pkg::TMC_SYNC_OFF;
		end else begin
			sync_state <= next_sync;
		end
	end

	//------------------------------------------------------------------
	// CRC configuration
	//------------------------------------------------------------------
	logic [15:0] next_crc_preset;
	logic        next_crc_msb;

	// Preset and bit order are resolved in a small selector ahead of the output stage.
	tmc_crc_select u_crc_select (
		.preset_select   (general_mode_settings[1:0]),
		.bit_order_flag  (general_mode_settings[`TMC_BIT_ORDER]),
		.rf_active       (rf_active),
		.proto_msb_first (proto_msb_first),
		.proto_preset    (proto_preset),
		.crc_preset      (next_crc_preset),
		.crc_msb_first   (next_crc_msb)
	);

	//------------------------------------------------------------------
	// Field gating, mode detector and envelope
	//------------------------------------------------------------------
	// Both gates test the level inputs in the cycle of the request.
	// A request that meets a closed gate is dropped; the transceiver must ask again.
	wire tx_blocked = general_mode_settings[`TMC_BIT_TX_WAIT] && reader_or_initiator &&
		!own_field_on; // R5
	wire rx_blocked = general_mode_settings[`TMC_BIT_RX_WAIT] && target_or_card &&
		!external_field_seen; // R6
	// The detector runs only inside the anticollision command and never when disabled.
	wire mdet_on    = anticollision_running &&
		!general_mode_settings[`TMC_BIT_MDET_OFF]; // R10 R11
	// Active-high pin passes inverted, active-low pin passes straight.
	wire env_n      = general_mode_settings[`TMC_BIT_POLARITY] ?
		!envelope_input_pin : envelope_input_pin; // R7 R9

	//------------------------------------------------------------------
	// Next values of the transceiver controls
	//------------------------------------------------------------------
	// The receiver stays off only while a sync byte is being hunted.
	wire next_rx_enable = (next_sync != tmc_pkg::TMC_SYNC_HUNT); // R3
	// Framing is asked to send F0h ahead of each frame while sync is on.
	wire next_send_sync = sync_on; // R3
	// Start requests pass unless the field gate holds them back.
	wire next_tx_start  = tx_start_request && !tx_blocked; // R5
	wire next_rx_wait   = rx_wait_start_request && !rx_blocked; // R6
	// The interrupt follows next status and mask so it never lags either.
	wire next_irq       = next_status && next_mask; // R8

	// CRC controls follow the selector one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_preset         <= `TMC_PRESET_0;
			crc_msb_first      <= 1'b0;
			crc_result_reverse <= 1'b0;
		end else begin
			crc_preset         <= next_crc_preset; // R12 R13
			crc_msb_first      <= next_crc_msb; // R1 R2
			crc_result_reverse <= next_crc_msb; // R1
		end
	end

	// Receiver, transmitter, detector, envelope, copy and interrupt outputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_enable            <= 1'b1;
			send_sync_byte       <= 1'b0;
			tx_start             <= 1'b0;
			rx_wait_start        <= 1'b0;
			mode_detector_enable <= 1'b0;
			envelope_internal_n  <= 1'b1;
			mode_settings        <= `TMC_RESET_MODE;
			irq                  <= 1'b0;
		end else begin
			rx_enable            <= next_rx_enable; // R3
			send_sync_byte       <= next_send_sync; // R3
			tx_start             <= next_tx_start; // R5
			rx_wait_start        <= next_rx_wait; // R6
			mode_detector_enable <= mdet_on; // R10 R11
			envelope_internal_n  <= env_n; // R9
			mode_settings        <= next_mode;
			irq                  <= next_irq; // R8
		end
	end
endmodule : tmc_mode_config

// ### dv/tmc_mode_config_props.sv
// Port checks for the mode configuration block.
`timescale 1ns/100ps
`include "tmc_defs.svh"
module tmc_mode_config_props (
	// Clock, reset and bus.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_bvalid,
	// Transceiver context.
	input  wire logic        rf_active,
	input  wire logic        proto_msb_first,
	input  wire logic [15:0] proto_preset,
	input  wire logic        mode_106k_active,
	input  wire logic        reader_or_initiator,
	input  wire logic        target_or_card,
	input  wire logic        own_field_on,
	input  wire logic        external_field_seen,
	input  wire logic        tx_start_request,
	input  wire logic        rx_wait_start_request,
	input  wire logic        anticollision_running,
	input  wire logic        envelope_input_pin,
	// Controls.
	input  wire logic [15:0] crc_preset,
	input  wire logic        crc_msb_first,
	input  wire logic        send_sync_byte,
	input  wire logic        tx_start,
	input  wire logic        rx_wait_start,
	input  wire logic        mode_detector_enable,
	input  wire logic        envelope_internal_n,
	input  wire logic [7:0]  mode_settings
);
	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	// All checks share the one clock and skip the reset cycles.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	crc_order_a: assert property (
		$past(aresetn) && $stable(mode_settings) && $stable(rf_active) && $stable(proto_msb_first)
		|-> crc_msb_first == (rf_active ? proto_msb_first : mode_settings[7]))
		else $error("crc bit order wrong");
	crc_preset_a: assert property (
		$past(aresetn) && $stable(mode_settings) && $stable(rf_active) && $stable(proto_preset)
		|-> crc_preset == (rf_active ? proto_preset : mode_settings[1] ?
		(mode_settings[0] ? `TMC_PRESET_3 : `TMC_PRESET_2) :
		(mode_settings[0] ? `TMC_PRESET_1 : `TMC_PRESET_0)))
		else $error("crc preset wrong");
	tx_gate_a: assert property ($past(aresetn) |-> tx_start == ($past(tx_start_request) &&
		!($past(mode_settings[5]) && $past(reader_or_initiator) && !$past(own_field_on))))
		else $error("transmit start gating wrong");
	rx_gate_a: assert property ($past(aresetn) |-> rx_wait_start ==
		($past(rx_wait_start_request) && !($past(mode_settings[4]) && $past(target_or_card)
		&& !$past(external_field_seen)))) else $error("receive wait gating wrong");
	mdet_gate_a: assert property ($past(aresetn) |-> mode_detector_enable ==
		($past(anticollision_running) && !$past(mode_settings[2])))
		else $error("mode detector enable wrong");
	env_pol_a: assert property ($past(aresetn) |-> envelope_internal_n ==
		($past(envelope_input_pin) ^ $past(mode_settings[3]))) else $error("envelope wrong");
	sync_out_a: assert property (
		$past(aresetn) && $stable(mode_settings) && $stable(mode_106k_active)
		|-> send_sync_byte == (mode_settings[6] && mode_106k_active))
		else $error("sync byte request wrong");
	reg_write_a: assert property ($changed(mode_settings) |-> $rose(s_axi_bvalid))
		else $error("register changed without a write");
endmodule : tmc_mode_config_props

// ### dv/test_tmc_mode_config.sv
// Self-checking bench for the mode configuration block.
`timescale 1ns/100ps
`include "tmc_defs.svh"
module test_tmc_mode_config;
	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte = 8'h00, mode_settings;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, last_rresp;
	logic [15:0] proto_preset = 16'h1234, crc_preset;
	logic [15:0] pre [4] = '{`TMC_PRESET_0, `TMC_PRESET_1, `TMC_PRESET_2, `TMC_PRESET_3};
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, rf_active = 1'b0, proto_msb_first = 1'b0, mode_106k_active = 1'b0;
	logic reader_or_initiator = 1'b0, target_or_card = 1'b0, own_field_on = 1'b0;
	logic external_field_seen = 1'b0, tx_start_request = 1'b0, rx_wait_start_request = 1'b0;
	logic anticollision_running = 1'b0, rx_byte_valid = 1'b0, frame_start = 1'b0;
	logic envelope_input_pin = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq, crc_msb_first, crc_result_reverse, rx_enable, send_sync_byte;
	logic tx_start, rx_wait_start, mode_detector_enable, envelope_internal_n;
	int   failures = 0, n_checks = 0;

	// Clock of 4 ns.
	always #2 aclk = ~aclk;

	tmc_mode_config dut (.*);

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	// Compares one result and counts it.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One write, each channel held until its ready, then the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask : wr
	// One read compared against an expected word.
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		last_rresp = s_axi_rresp;
		chk(s_axi_rdata, e);
	endtask : rc
	// Lets registered outputs settle, then stops between edges.
	task automatic st();
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask : st
	// Writes the mode register and waits for its effects.
	task automatic ms(input logic [7:0] d);
		wr(`TMC_ADDR_MODE, 32'(d), `TMC_RESP_OKAY);
		st();
	endtask : ms
	// One start request on both gated paths.
	task automatic req();
		@(posedge aclk);
		tx_start_request <= 1'b1;
		rx_wait_start_request <= 1'b1;
		@(posedge aclk);
		tx_start_request <= 1'b0;
		rx_wait_start_request <= 1'b0;
		@(negedge aclk);
	endtask : req
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	// Main sequence.
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`TMC_ADDR_MODE, 32'h3b);
		ms(8'ha5);
		chk(32'(mode_settings), 32'ha5);
		rc(`TMC_ADDR_MODE, 32'ha5);
		rc(`TMC_ADDR_MODE, 32'ha5);
		wr(8'h20, 32'hff, `TMC_RESP_SLVERR);
		rc(8'h20, 32'h0);
		chk(32'(last_rresp), 32'(`TMC_RESP_SLVERR));
		rc(`TMC_ADDR_MODE, 32'ha5);
		chk(32'(last_rresp), 32'(`TMC_RESP_OKAY));
		for (int i = 0; i < 4; i++) begin
			ms(8'(i));
			chk(32'(crc_preset), 32'(pre[i]));
		end
		ms(8'h83);
		chk(32'({crc_msb_first, crc_result_reverse}), 32'h3);
		@(posedge aclk);
		rf_active <= 1'b1;
		st();
		chk(32'({crc_msb_first, crc_preset}), 32'h01234);
		rc(`TMC_ADDR_EVT_STATUS, 32'h1);
		wr(`TMC_ADDR_EVT_STATUS, 32'h1, `TMC_RESP_OKAY);
		wr(`TMC_ADDR_EVT_MASK, 32'h1, `TMC_RESP_OKAY);
		st();
		chk(32'(irq), 32'h0);
		rc(`TMC_ADDR_EVT_MASK, 32'h1);
		ms(8'h8b);
		chk(32'(irq), 32'h1);
		rc(`TMC_ADDR_EVT_STATUS, 32'h1);
		wr(`TMC_ADDR_EVT_STATUS, 32'h1, `TMC_RESP_OKAY);
		ms(8'h8f);
		chk(32'(irq), 32'h0);
		for (int j = 0; j < 4; j++) begin
			@(posedge aclk);
			envelope_input_pin <= j[0];
			ms({4'h0, j[1], 3'h0});
			chk(32'(envelope_internal_n), 32'(j[0] ^ j[1]));
		end
		@(posedge aclk);
		anticollision_running <= 1'b1;
		ms(8'h04);
		chk(32'(mode_detector_enable), 32'h0);
		ms(8'h00);
		chk(32'(mode_detector_enable), 32'h1);
		@(posedge aclk);
		anticollision_running <= 1'b0;
		reader_or_initiator <= 1'b1;
		target_or_card <= 1'b1;
		ms(8'h30);
		chk(32'(mode_detector_enable), 32'h0);
		req();
		chk(32'({tx_start, rx_wait_start}), 32'h0);
		@(posedge aclk);
		own_field_on <= 1'b1;
		external_field_seen <= 1'b1;
		req();
		chk(32'({tx_start, rx_wait_start}), 32'h3);
		@(posedge aclk);
		mode_106k_active <= 1'b1;
		frame_start <= 1'b1;
		ms(8'h40);
		chk(32'(send_sync_byte), 32'h1);
		@(posedge aclk);
		frame_start <= 1'b0;
		rx_byte <= 8'h55;
		rx_byte_valid <= 1'b1;
		st();
		chk(32'(rx_enable), 32'h0);
		@(posedge aclk);
		rx_byte <= `TMC_SYNC_BYTE;
		@(posedge aclk);
		rx_byte_valid <= 1'b0;
		st();
		chk(32'(rx_enable), 32'h1);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`TMC_ADDR_MODE, 32'h3b);
		report_and_stop();
	end

	// Cuts a hang short well after the tests should have ended.
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
endmodule : test_tmc_mode_config

bind tmc_mode_config tmc_mode_config_props props (.*);
